/* vpd_decode.sv */
`timescale 1ns/100ps
`include "vpd_consts.svh"
module vpd_decode
  import vpd_pkg::*;
(
  // clock and reset
  input  wire logic          REF_CLK_I,
  input  wire logic          RST_I,
  // configuration strap
  input  wire logic          MOTHERBOARD_I,
  // host byte io cycle
  input  wire logic          IO_RD_I,
  input  wire logic          IO_WR_I,
  input  vpd_pkg::vpd_addr_t IO_ADDR_I,
  input  vpd_pkg::vpd_byte_t IO_WDATA_I,
  // host answer
  output vpd_pkg::vpd_byte_t IO_RDATA_O,
  output logic               IO_RDATA_OE_O,
  output logic               IO_CLAIM_O,
  // status inputs from display logic
  input  vpd_pkg::vpd_byte_t STAT0_I,
  input  vpd_pkg::vpd_byte_t STAT1_I,
  // decode gate to rest of chip
  output logic               DECODE_EN_O,
  output logic               COLOR_MODE_O
);
  import vpd_pkg::*;

  typedef struct packed {
    vpd_byte_t  mb_en;
    vpd_byte_t  shared_en;
    vpd_byte_t  adp_en;
    vpd_byte_t  misc;
    vpd_byte_t  feat;
    vpd_byte_t  crt_idx;
    vpd_byte_t  rdata;
    logic       rdata_oe;
    logic       claim;
    logic       dec_en;
    logic       color;
    vpd_state_t state;
  } vpd_st_t;

  vpd_st_t st_reg;
  vpd_st_t st_next;

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  logic      mb;
  logic      en;
  logic      shared_open;
  logic      hit_mb;
  logic      hit_alt;
  logic      hit_adp;
  logic      hit_shr;
  logic      hit_s0;
  logic      hit_misc_rd;
  logic      hit_feat_rd;
  logic      hit_cidx;
  logic      hit_cdat;
  logic      hit_s1;
  logic      crt_wr;
  vpd_byte_t crt_rdata;

  assign mb  = MOTHERBOARD_I;
  assign en  = st_reg.dec_en;
  // unlocked only with adaptor setup high and motherboard setup low
  assign shared_open = st_reg.adp_en[`VPD_ADP_SETUP_BIT] & ~st_reg.mb_en[`VPD_MB_SETUP_BIT];
  assign hit_mb  = mb & (IO_ADDR_I == `VPD_PORT_MB_EN);
  assign hit_alt = mb & (IO_ADDR_I == `VPD_PORT_MB_EN_ALT);
  assign hit_adp = ~mb & (IO_ADDR_I == `VPD_PORT_ADP_EN);
  assign hit_shr = shared_open & (IO_ADDR_I == `VPD_PORT_SHARED_EN);
  // gated vga ports only respond while decoding is on
  assign hit_s0      = en & (IO_ADDR_I == `VPD_PORT_STAT0_MISC);
  assign hit_misc_rd = en & (IO_ADDR_I == `VPD_PORT_MISC_RD);
  assign hit_feat_rd = en & (IO_ADDR_I == `VPD_PORT_FEAT_RD);
  // mono/colour placement follows misc bit 0
  assign hit_cidx = en & (IO_ADDR_I == (st_reg.color ? `VPD_PORT_CRT_IDX_C : `VPD_PORT_CRT_IDX_M));
  assign hit_cdat = en & (IO_ADDR_I == (st_reg.color ? `VPD_PORT_CRT_DAT_C : `VPD_PORT_CRT_DAT_M));
  assign hit_s1   = en & (IO_ADDR_I == (st_reg.color ? `VPD_PORT_STAT1_C : `VPD_PORT_STAT1_M));
  assign crt_wr   = IO_WR_I & hit_cdat & (st_reg.crt_idx <= 8'(`VPD_CRT_LAST_IDX));

  ////////////////////////////////////////////////////////////////////////////
  // indexed crt data bank
  vpd_crt_bank u_crt (
    .clk_i   (REF_CLK_I),
    .rst_i   (RST_I),
    .wr_i    (crt_wr),
    .idx_i   (st_reg.crt_idx[4:0]),
    .wdata_i (IO_WDATA_I),
    .rdata_o (crt_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state: writes, read mux, answer strobes
  always_comb begin
    st_next = st_reg;
    st_next.rdata_oe = 1'b0;
    st_next.claim    = 1'b0;
    st_next.state    = VPD_IDLE;
    if (IO_WR_I) begin
      if (hit_mb || hit_alt) begin
        st_next.mb_en = IO_WDATA_I;
      end
      if (hit_adp) begin
        st_next.adp_en = IO_WDATA_I;
      end
      if (hit_shr) begin
        st_next.shared_en = IO_WDATA_I;
      end
      if (hit_s0) begin
        st_next.misc = IO_WDATA_I;
      end
      if (hit_s1) begin
        st_next.feat = IO_WDATA_I;
      end
      if (hit_cidx) begin
        st_next.crt_idx = IO_WDATA_I;
      end
      st_next.claim = hit_mb | hit_alt | hit_adp | hit_shr | hit_s0 | hit_s1 | hit_cidx | hit_cdat;
    end else if (IO_RD_I) begin
      st_next.claim    = 1'b1;
      st_next.rdata_oe = 1'b1;
      st_next.state    = VPD_ANS;
      if (hit_mb || hit_alt) begin
        st_next.rdata = st_reg.mb_en;
      end else if (hit_adp) begin
        st_next.rdata = st_reg.adp_en;
      end else if (hit_shr) begin
        st_next.rdata = st_reg.shared_en;
      end else if (hit_s0) begin
        st_next.rdata = STAT0_I;
      end else if (hit_misc_rd) begin
        st_next.rdata = st_reg.misc;
      end else if (hit_feat_rd) begin
        st_next.rdata = st_reg.feat;
      end else if (hit_s1) begin
        st_next.rdata = STAT1_I;
      end else if (hit_cidx) begin
        st_next.rdata = st_reg.crt_idx;
      end else if (hit_cdat) begin
        // bank sees only five index bits, so high indices would alias
        st_next.rdata = (st_reg.crt_idx <= 8'(`VPD_CRT_LAST_IDX)) ? crt_rdata : `VPD_RST_BYTE;
      end else begin
        // nothing claimed: leave bus to others
        st_next.claim    = 1'b0;
        st_next.rdata_oe = 1'b0;
        st_next.state    = VPD_IDLE;
        st_next.rdata    = `VPD_RST_BYTE;
      end
    end
    // with the motherboard strap both enable paths must agree, adaptor uses 102 alone; gate updated from the new values
    case (mb)
      1'b1: st_next.dec_en = st_next.mb_en[`VPD_MB_SETUP_BIT] & st_next.mb_en[`VPD_MB_ENABLE_BIT]
                             & st_next.shared_en[`VPD_SHARED_EN_BIT];
      1'b0: st_next.dec_en = st_next.shared_en[`VPD_SHARED_EN_BIT];
      default: st_next.dec_en = 1'b0;
    endcase
    st_next.color = st_next.misc[`VPD_MISC_COLOR_BIT];
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; only the adaptor enable comes up with its setup bit set, so software can reach port 102
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      st_reg          <= '0;
      st_reg.adp_en   <= `VPD_RST_ADP_EN;
    end else begin
      st_reg <= st_next;
    end
  end

  assign IO_RDATA_O    = st_reg.rdata;
  assign IO_RDATA_OE_O = st_reg.rdata_oe;
  assign IO_CLAIM_O    = st_reg.claim;
  assign DECODE_EN_O   = st_reg.dec_en;
  assign COLOR_MODE_O  = st_reg.color;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  mb_gate_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    MOTHERBOARD_I && !st_reg.mb_en[5] |-> !DECODE_EN_O) else $error("decode on with 94 bit5 low");
  shared_gate_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    !st_reg.shared_en[0] |-> !DECODE_EN_O) else $error("decode on with 102 bit0 low");
  shared_lock_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    IO_WR_I && IO_ADDR_I == 16'h0102 && !shared_open && $stable(MOTHERBOARD_I)
    |=> $stable(st_reg.shared_en)) else $error("locked 102 changed");
  adp_ignore_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    !MOTHERBOARD_I && IO_WR_I && IO_ADDR_I == 16'h0094 |=> $stable(st_reg.mb_en))
    else $error("adaptor took 94 write");
  mb_no46_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    MOTHERBOARD_I && (IO_RD_I || IO_WR_I) && IO_ADDR_I == 16'h46E8 |=> !IO_CLAIM_O)
    else $error("motherboard claimed 46E8");
  idx_write_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    IO_WR_I && hit_cidx |=> st_reg.crt_idx == $past(IO_WDATA_I)) else $error("crt index lost");
  misc_read_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    IO_RD_I && !IO_WR_I && hit_misc_rd |=> IO_RDATA_O == st_reg.misc && IO_RDATA_OE_O)
    else $error("3CC readback");
  stat1_read_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    IO_RD_I && !IO_WR_I && hit_s1 |=> IO_RDATA_O == $past(STAT1_I)) else $error("status1 read");
  color_sel_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    IO_WR_I && hit_s0 |=> COLOR_MODE_O == $past(IO_WDATA_I[0])) else $error("placement not misc bit0");
  quiet_off_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    !DECODE_EN_O && IO_RD_I && IO_ADDR_I == 16'h03CC |=> !IO_RDATA_OE_O) else $error("drove while off");
  mb_bit3_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    MOTHERBOARD_I && !st_reg.mb_en[3] |-> !DECODE_EN_O) else $error("decode on with 94 bit3 low");
  // a gated port must not be claimed either, or the bus sees two answers
  claim_off_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    !DECODE_EN_O && IO_RD_I && !IO_WR_I && IO_ADDR_I == 16'h03C2 |=> !IO_CLAIM_O)
    else $error("claimed while off");
endmodule

/* vpd_consts.svh */
`ifndef VPD_CONSTS_SVH
`define VPD_CONSTS_SVH
// port addresses
`define VPD_PORT_MB_EN      16'h0094
`define VPD_PORT_SHARED_EN  16'h0102
`define VPD_PORT_MB_EN_ALT  16'h03C3
`define VPD_PORT_ADP_EN     16'h46E8
`define VPD_PORT_STAT0_MISC 16'h03C2
`define VPD_PORT_MISC_RD    16'h03CC
`define VPD_PORT_FEAT_RD    16'h03CA
`define VPD_PORT_CRT_IDX_C  16'h03D4
`define VPD_PORT_CRT_DAT_C  16'h03D5
`define VPD_PORT_STAT1_C    16'h03DA
`define VPD_PORT_CRT_IDX_M  16'h03B4
`define VPD_PORT_CRT_DAT_M  16'h03B5
`define VPD_PORT_STAT1_M    16'h03BA
// field positions
`define VPD_MB_SETUP_BIT    5
`define VPD_MB_ENABLE_BIT   3
`define VPD_ADP_SETUP_BIT   4
`define VPD_SHARED_EN_BIT   0
`define VPD_MISC_COLOR_BIT  0
// crt index range and count
`define VPD_CRT_LAST_IDX    5'h1D
`define VPD_CRT_NREG        30
// reset values
`define VPD_RST_BYTE        8'h00
`define VPD_RST_ADP_EN      8'h10
`endif

/* vpd_pkg.sv */
package vpd_pkg;
  typedef logic [15:0] vpd_addr_t;
  typedef logic [7:0]  vpd_byte_t;
  typedef enum logic [1:0] {
    VPD_IDLE = 2'b00,
    VPD_ANS  = 2'b01
  } vpd_state_t;
endpackage

/* vpd_crt_bank.sv */
`timescale 1ns/100ps
`include "vpd_consts.svh"
// indexed crt controller data registers, 00..1D
module vpd_crt_bank
  import vpd_pkg::*;
(
  // clock and reset
  input  wire logic      clk_i,
  input  wire logic      rst_i,
  // access
  input  wire logic      wr_i,
  input  wire logic [4:0] idx_i,
  input  vpd_pkg::vpd_byte_t wdata_i,
  output vpd_pkg::vpd_byte_t rdata_o
);
  import vpd_pkg::*;

  typedef struct packed {
    logic [`VPD_CRT_NREG-1:0][7:0] regs;
  } vpd_crt_st_t;
  vpd_crt_st_t st_reg;
  vpd_crt_st_t st_next;

  // one write port; indices 00..18 standard timing, 19..1D extensions
  always_comb begin
    st_next = st_reg;
    for (int i = 0; i < `VPD_CRT_NREG; i++) begin
      if (wr_i && idx_i == 5'(i)) begin
        st_next.regs[i] = wdata_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // out-of-range indices read zero
  assign rdata_o = (idx_i <= `VPD_CRT_LAST_IDX) ? st_reg.regs[idx_i] : `VPD_RST_BYTE;
endmodule

/* vpd_host_model.sv */
`timescale 1ns/100ps
// host processor side: byte io cycles with one-cycle strobes
module vpd_host_model
  import vpd_pkg::*;
(
  // clock
  input  wire logic         clk_i,
  // cycle to the device
  output logic               rd_o,
  output logic               wr_o,
  output vpd_pkg::vpd_addr_t addr_o,
  output vpd_pkg::vpd_byte_t wdata_o,
  // answer from the device
  input  vpd_pkg::vpd_byte_t rdata_i,
  input  wire logic          oe_i,
  input  wire logic          claim_i
);
  // idle bus, no strobe
  initial begin
    rd_o = 1'b0;
    wr_o = 1'b0;
    addr_o = 16'hFFFF;
    wdata_o = 8'hFF;
  end
  ////////////////////////////////////////////////////////////////
  // strobe held over one edge; address and data inverted after release
  // so a device that samples late never sees the old values
  task automatic xfer(input logic wr, input vpd_addr_t a, input vpd_byte_t d,
                      output logic claim, output logic oe, output vpd_byte_t q);
    @(negedge clk_i);
    wr_o = wr;
    rd_o = !wr;
    addr_o = a;
    wdata_o = d;
    @(negedge clk_i);
    claim = claim_i;
    oe = oe_i;
    q = rdata_i;
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask
endmodule

/* vga_io_port_decode_enable_tb.sv */
`timescale 1ns/100ps
module vga_io_port_decode_enable_tb;
  import vpd_pkg::*;
  logic      ref_clk, rst, mb, rd, wr, oe, claim, den, color;
  vpd_addr_t addr;
  vpd_byte_t wdata, rdata, stat0, stat1;
  int        miscompares = 0;
  int        cmp_count = 0;
  // design and host
  vpd_decode dut (.REF_CLK_I(ref_clk), .RST_I(rst), .MOTHERBOARD_I(mb), .IO_RD_I(rd), .IO_WR_I(wr),
    .IO_ADDR_I(addr), .IO_WDATA_I(wdata), .IO_RDATA_O(rdata), .IO_RDATA_OE_O(oe), .IO_CLAIM_O(claim),
    .STAT0_I(stat0), .STAT1_I(stat1), .DECODE_EN_O(den), .COLOR_MODE_O(color));
  vpd_host_model host (.clk_i(ref_clk), .rd_o(rd), .wr_o(wr), .addr_o(addr), .wdata_o(wdata),
    .rdata_i(rdata), .oe_i(oe), .claim_i(claim));
  // 100 MHz clock
  always #5 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr_port(input vpd_addr_t a, input vpd_byte_t d, input logic hit);
    logic c, o;
    vpd_byte_t q;
    host.xfer(1'b1, a, d, c, o, q);
    chk("write claim", {7'h0, hit}, {7'h0, c});
    chk("write drive", 8'h00, {7'h0, o});
  endtask
  task automatic rd_port(input vpd_addr_t a, input logic hit, input vpd_byte_t exp);
    logic c, o;
    vpd_byte_t q;
    host.xfer(1'b0, a, 8'h00, c, o, q);
    chk("read claim", {7'h0, hit}, {7'h0, c});
    chk("read drive", {7'h0, hit}, {7'h0, o});
    if (hit) chk("read data", exp, q);
  endtask
  task automatic test_done();
    $display("compares %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // watchdog: a hung run is a failure
  initial begin
    repeat (5000) @(posedge ref_clk);
    miscompares++;
    test_done();
  end
  // main sequence: adaptor strap first, then motherboard strap
  initial begin
    logic [7:0] idx [4] = '{8'h00, 8'h18, 8'h19, 8'h1D};
    ref_clk = 1'b0;
    rst = 1'b1;
    mb = 1'b0;
    stat0 = 8'h90;
    stat1 = 8'h09;
    repeat (3) @(negedge ref_clk);
    rst = 1'b0;
    rd_port(16'h03C2, 1'b0, 8'h00);
    wr_port(16'h0094, 8'h28, 1'b0);
    wr_port(16'h03C3, 8'h28, 1'b0);
    wr_port(16'h0102, 8'h01, 1'b1);
    chk("decode gate", 8'h01, {7'h0, den});
    rd_port(16'h46E8, 1'b1, 8'h10);
    rd_port(16'h03C2, 1'b1, 8'h90);
    wr_port(16'h03C2, 8'h01, 1'b1);
    chk("colour mode", 8'h01, {7'h0, color});
    rd_port(16'h03CC, 1'b1, 8'h01);
    // write all indices before reading so aliasing shows
    foreach (idx[i]) begin
      wr_port(16'h03D4, idx[i], 1'b1);
      wr_port(16'h03D5, idx[i] ^ 8'hA5, 1'b1);
    end
    foreach (idx[i]) begin
      wr_port(16'h03D4, idx[i], 1'b1);
      rd_port(16'h03D4, 1'b1, idx[i]);
      rd_port(16'h03D5, 1'b1, idx[i] ^ 8'hA5);
    end
    // index beyond 1D: write dropped, read zero, no alias onto 19
    wr_port(16'h03D4, 8'h39, 1'b1);
    wr_port(16'h03D5, 8'h77, 1'b1);
    rd_port(16'h03D5, 1'b1, 8'h00);
    wr_port(16'h03D4, 8'h19, 1'b1);
    rd_port(16'h03D5, 1'b1, 8'hBC);
    rd_port(16'h03DA, 1'b1, 8'h09);
    wr_port(16'h03DA, 8'h5A, 1'b1);
    rd_port(16'h03CA, 1'b1, 8'h5A);
    rd_port(16'h03BA, 1'b0, 8'h00);
    wr_port(16'h03C2, 8'h00, 1'b1);
    rd_port(16'h03BA, 1'b1, 8'h09);
    wr_port(16'h46E8, 8'h00, 1'b1);
    wr_port(16'h0102, 8'h00, 1'b0);
    chk("decode gate", 8'h01, {7'h0, den});
    // second reset with motherboard strap
    rst = 1'b1;
    mb = 1'b1;
    repeat (3) @(negedge ref_clk);
    rst = 1'b0;
    chk("decode gate", 8'h00, {7'h0, den});
    wr_port(16'h46E8, 8'h10, 1'b0);
    wr_port(16'h0102, 8'h01, 1'b1);
    wr_port(16'h0094, 8'h08, 1'b1);
    chk("decode gate", 8'h00, {7'h0, den});
    wr_port(16'h03C3, 8'h28, 1'b1);
    chk("decode gate", 8'h01, {7'h0, den});
    wr_port(16'h0102, 8'h00, 1'b0);
    wr_port(16'h0094, 8'h20, 1'b1);
    chk("decode gate", 8'h00, {7'h0, den});
    rd_port(16'h03C2, 1'b0, 8'h00);
    rd_port(16'h03CC, 1'b0, 8'h00);
    test_done();
  end
endmodule
